// ### hw/vec_consts.svh
// Constants for the VM entry control capability check
// Assumes one core clock and a plain register port indexed by register number
`ifndef VEC_CONSTS_SVH
`define VEC_CONSTS_SVH

// ======================================================================
// Register indices
`define VEC_OFF_PIN_CAP       12'h481
`define VEC_OFF_PROC_CAP      12'h482
`define VEC_OFF_PIN_TRUE_CAP  12'h48d
`define VEC_OFF_PROC_TRUE_CAP 12'h48e
`define VEC_OFF_BASIC_CAP     12'h4a0
`define VEC_OFF_PIN_CTL       12'h4a1
`define VEC_OFF_PROC_CTL      12'h4a2
`define VEC_OFF_CMD           12'h4a3
`define VEC_OFF_STATUS        12'h4a4
`define VEC_OFF_CLEAR         12'h4a5
`define VEC_OFF_ENABLE        12'h4a6
`define VEC_OFF_VIOL_PIN      12'h4a7
`define VEC_OFF_VIOL_PROC     12'h4a8
`define VEC_OFF_COUNT         12'h4a9

// ======================================================================
// Field positions
`define VEC_BASIC_TRUE_BIT    55
`define VEC_CMD_START_BIT     0
`define VEC_EVT_PASS_BIT      0
`define VEC_EVT_FAIL_BIT      1

// ======================================================================
// Default-one classes
`define VEC_PIN_DEF1          32'h0000_0016
`define VEC_PROC_DEF1         32'h0401_e172

// ======================================================================
// Reset values
`define VEC_CTL_RST           32'h0000_0000
`define VEC_EVT_RST           2'h0
`define VEC_CNT_RST           16'h0000
`define VEC_DATA_RST          64'h0000_0000_0000_0000

// ======================================================================
// Capability defaults
`define VEC_BASIC_CAP_DEF     64'h0080_0000_0000_0000
`define VEC_PIN_CAP_DEF       64'h0000_007f_0000_0016
`define VEC_PIN_TRUE_CAP_DEF  64'h0000_007f_0000_0000
`define VEC_PROC_CAP_DEF      64'hffff_fffe_0401_e172
`define VEC_PROC_TRUE_CAP_DEF 64'hffff_fffe_0000_0000

`endif

// ### hw/vec_pkg.sv
// Types for the VM entry control capability check
// Assumes no numbers from vec_consts.svh; widths are written in place
package vec_pkg;

  // ======================================================================
  // Per-word violation vectors
  typedef struct packed {
    logic [31:0] zero_viol;
    logic [31:0] one_viol;
    logic [31:0] def1_viol;
  } vec_viol_t;

  typedef logic [63:0] vec_cap_t;
  typedef logic [31:0] vec_ctl_t;

endpackage : vec_pkg

// ### hw/vec_chk_if.sv
// Carrier between the top and one control word checker
// Assumes one instance per control word
`timescale 1ns/100ps
`default_nettype none

interface vec_chk_if;
  import vec_pkg::*;

  vec_ctl_t  ctl;
  vec_cap_t  cap;
  vec_ctl_t  def1;
  logic      true_en;
  vec_viol_t viol;

  modport chk (input ctl, input cap, input def1, input true_en, output viol);
  modport own (output ctl, output cap, output def1, output true_en, input viol);

endinterface : vec_chk_if

`default_nettype wire

// ### hw/vec_word_check.sv
// Checks one control word against its effective capability
// Assumes the top hands over the capability already chosen by basic bit 55
`timescale 1ns/100ps
`default_nettype none

module vec_word_check
  import vec_pkg::*;
(
  vec_chk_if.chk bus
);

  // ======================================================================
  // Per-bit checks
  genvar x;
  generate
    for (x = 0; x < 32; x = x + 1) begin : g_bit
      assign bus.viol.zero_viol[x] = bus.cap[x] & ~bus.ctl[x];
      assign bus.viol.one_viol[x]  = ~bus.cap[32 + x] & bus.ctl[x];
      assign bus.viol.def1_viol[x] = ~bus.true_en & bus.def1[x] & ~bus.ctl[x];
    end
  endgenerate

endmodule : vec_word_check

`default_nettype wire

// ### hw/vec_entry_check.sv
// Top of the VM entry control capability check
// Assumes a register port on the core clock, read data one cycle after the strobe
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "vec_consts.svh"

module vec_entry_check
  import vec_pkg::*;
#(
  parameter vec_cap_t P_BASIC_CAP     = `VEC_BASIC_CAP_DEF,
  parameter vec_cap_t P_PIN_CAP       = `VEC_PIN_CAP_DEF,
  parameter vec_cap_t P_PIN_TRUE_CAP  = `VEC_PIN_TRUE_CAP_DEF,
  parameter vec_cap_t P_PROC_CAP      = `VEC_PROC_CAP_DEF,
  parameter vec_cap_t P_PROC_TRUE_CAP = `VEC_PROC_TRUE_CAP_DEF
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [11:0] i_addr,
  input  wire logic [63:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [63:0] o_rdata,
  output var  logic        o_entry_done,
  output var  logic        o_entry_fail,
  output var  logic        o_irq
);

  // ======================================================================
  // Effective capabilities
  logic     true_en;
  vec_cap_t pin_std_rd;
  vec_cap_t proc_std_rd;
  vec_cap_t pin_true_rd;
  vec_cap_t proc_true_rd;

  assign true_en      = P_BASIC_CAP[`VEC_BASIC_TRUE_BIT];
  assign pin_std_rd   = P_PIN_CAP | {32'h0000_0000, `VEC_PIN_DEF1};
  assign proc_std_rd  = P_PROC_CAP | {32'h0000_0000, `VEC_PROC_DEF1};
  assign pin_true_rd  = true_en ? P_PIN_TRUE_CAP : `VEC_DATA_RST;
  assign proc_true_rd = true_en ? P_PROC_TRUE_CAP : `VEC_DATA_RST;

  // ======================================================================
  // Register state
  vec_ctl_t    pin_ctl;
  vec_ctl_t    proc_ctl;
  logic [1:0]  status;
  logic [1:0]  enable;
  vec_ctl_t    viol_pin;
  vec_ctl_t    viol_proc;
  logic [15:0] pass_cnt;
  logic [15:0] fail_cnt;

  vec_ctl_t    next_pin_ctl;
  vec_ctl_t    next_proc_ctl;
  logic [1:0]  next_status;
  logic [1:0]  next_enable;
  vec_ctl_t    next_viol_pin;
  vec_ctl_t    next_viol_proc;
  logic [15:0] next_pass_cnt;
  logic [15:0] next_fail_cnt;
  logic [63:0] next_rdata;
  logic        next_done;
  logic        next_fail;
  logic        next_irq;

  // ======================================================================
  // Word checkers
  vec_chk_if pin_bus ();
  vec_chk_if proc_bus ();

  assign pin_bus.ctl      = pin_ctl;
  assign pin_bus.cap      = true_en ? P_PIN_TRUE_CAP : pin_std_rd;
  assign pin_bus.def1     = `VEC_PIN_DEF1;
  assign pin_bus.true_en  = true_en;
  assign proc_bus.ctl     = proc_ctl;
  assign proc_bus.cap     = true_en ? P_PROC_TRUE_CAP : proc_std_rd;
  assign proc_bus.def1    = `VEC_PROC_DEF1;
  assign proc_bus.true_en = true_en;

  vec_word_check u_pin_check (
    .bus (pin_bus.chk)
  );

  vec_word_check u_proc_check (
    .bus (proc_bus.chk)
  );

  // ======================================================================
  // Entry decision
  logic     start;
  logic     fail_any;
  vec_ctl_t pin_or;
  vec_ctl_t proc_or;

  assign start = i_wr && (i_addr == `VEC_OFF_CMD) && i_wdata[`VEC_CMD_START_BIT];
  assign pin_or  = pin_bus.viol.zero_viol | pin_bus.viol.one_viol
                 | pin_bus.viol.def1_viol;
  assign proc_or = proc_bus.viol.zero_viol | proc_bus.viol.one_viol
                 | proc_bus.viol.def1_viol;
  assign fail_any = (|pin_or) | (|proc_or);

  // ======================================================================
  // Control words and enables
  always_comb begin
    next_pin_ctl  = pin_ctl;
    next_proc_ctl = proc_ctl;
    next_enable   = enable;
    if (i_wr) begin
      case (i_addr)
        `VEC_OFF_PIN_CTL:  next_pin_ctl  = i_wdata[31:0];
        `VEC_OFF_PROC_CTL: next_proc_ctl = i_wdata[31:0];
        `VEC_OFF_ENABLE:   next_enable   = i_wdata[1:0];
        default: begin
          next_pin_ctl = pin_ctl;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_ctl  <= `VEC_CTL_RST;
      proc_ctl <= `VEC_CTL_RST;
      enable   <= `VEC_EVT_RST;
    end else begin
      pin_ctl  <= next_pin_ctl;
      proc_ctl <= next_proc_ctl;
      enable   <= next_enable;
    end
  end

  // ======================================================================
  // Results and counters
  always_comb begin
    next_done      = start;
    next_fail      = start & fail_any;
    next_viol_pin  = viol_pin;
    next_viol_proc = viol_proc;
    next_pass_cnt  = pass_cnt;
    next_fail_cnt  = fail_cnt;
    if (start) begin
      next_viol_pin  = pin_or;
      next_viol_proc = proc_or;
      if (fail_any) begin
        next_fail_cnt = fail_cnt + 16'h0001;
      end else begin
        next_pass_cnt = pass_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_entry_done <= 1'b0;
      o_entry_fail <= 1'b0;
      viol_pin     <= `VEC_CTL_RST;
      viol_proc    <= `VEC_CTL_RST;
      pass_cnt     <= `VEC_CNT_RST;
      fail_cnt     <= `VEC_CNT_RST;
    end else begin
      o_entry_done <= next_done;
      o_entry_fail <= next_fail;
      viol_pin     <= next_viol_pin;
      viol_proc    <= next_viol_proc;
      pass_cnt     <= next_pass_cnt;
      fail_cnt     <= next_fail_cnt;
    end
  end

  // ======================================================================
  // Event status and interrupt
  logic [1:0] clr;
  logic [1:0] set;

  always_comb begin
    clr = 2'h0;
    if (i_wr && (i_addr == `VEC_OFF_CLEAR)) begin
      clr = i_wdata[1:0];
    end
    set = 2'h0;
    set[`VEC_EVT_PASS_BIT] = start & ~fail_any;
    set[`VEC_EVT_FAIL_BIT] = start & fail_any;
    next_status = (status & ~clr) | set;
    next_irq    = |(next_status & next_enable);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status <= `VEC_EVT_RST;
      o_irq  <= 1'b0;
    end else begin
      status <= next_status;
      o_irq  <= next_irq;
    end
  end

  // ======================================================================
  // Read port
  always_comb begin
    next_rdata = `VEC_DATA_RST;
    if (i_rd) begin
      case (i_addr)
        `VEC_OFF_BASIC_CAP:     next_rdata = P_BASIC_CAP;
        `VEC_OFF_PIN_CAP:       next_rdata = pin_std_rd;
        `VEC_OFF_PROC_CAP:      next_rdata = proc_std_rd;
        `VEC_OFF_PIN_TRUE_CAP:  next_rdata = pin_true_rd;
        `VEC_OFF_PROC_TRUE_CAP: next_rdata = proc_true_rd;
        `VEC_OFF_PIN_CTL:       next_rdata = {32'h0000_0000, pin_ctl};
        `VEC_OFF_PROC_CTL:      next_rdata = {32'h0000_0000, proc_ctl};
        `VEC_OFF_STATUS:        next_rdata = {62'h0, status};
        `VEC_OFF_ENABLE:        next_rdata = {62'h0, enable};
        `VEC_OFF_VIOL_PIN:      next_rdata = {32'h0000_0000, viol_pin};
        `VEC_OFF_VIOL_PROC:     next_rdata = {32'h0000_0000, viol_proc};
        `VEC_OFF_COUNT:         next_rdata = {32'h0000_0000, fail_cnt, pass_cnt};
        default:                next_rdata = `VEC_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= `VEC_DATA_RST;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule : vec_entry_check

`default_nettype wire

// ### bench/vec_entry_check_assertions.sv
// Port checker for the VM entry control capability check
// Assumes it is bound to every vec_entry_check instance
`timescale 1ns/100ps
`default_nettype none
`include "vec_consts.svh"
module vec_entry_check_assertions
  import vec_pkg::*;
#(
  parameter vec_cap_t P_BASIC_CAP     = `VEC_BASIC_CAP_DEF,
  parameter vec_cap_t P_PIN_CAP       = `VEC_PIN_CAP_DEF,
  parameter vec_cap_t P_PIN_TRUE_CAP  = `VEC_PIN_TRUE_CAP_DEF,
  parameter vec_cap_t P_PROC_CAP      = `VEC_PROC_CAP_DEF,
  parameter vec_cap_t P_PROC_TRUE_CAP = `VEC_PROC_TRUE_CAP_DEF
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [11:0] i_addr,
  input wire logic [63:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [63:0] o_rdata,
  input wire logic        o_entry_done,
  input wire logic        o_entry_fail,
  input wire logic        o_irq
);
  // ======================================================================
  // Shadow control words and expected verdict
  localparam logic     TRUE_EN = P_BASIC_CAP[`VEC_BASIC_TRUE_BIT];
  localparam vec_cap_t PIN_S   = P_PIN_CAP | {32'h0000_0000, `VEC_PIN_DEF1};
  localparam vec_cap_t PROC_S  = P_PROC_CAP | {32'h0000_0000, `VEC_PROC_DEF1};
  localparam vec_cap_t PIN_E   = TRUE_EN ? P_PIN_TRUE_CAP : PIN_S;
  localparam vec_cap_t PROC_E  = TRUE_EN ? P_PROC_TRUE_CAP : PROC_S;
  vec_ctl_t pin_ctl;
  vec_ctl_t proc_ctl;
  vec_ctl_t next_pin_ctl;
  vec_ctl_t next_proc_ctl;
  logic     exp_fail;
  logic     start_w;
  function automatic logic bad(input vec_cap_t c, input vec_ctl_t x);
    return (|(c[31:0] & ~x)) | (|(~c[63:32] & x));
  endfunction : bad
  assign start_w  = i_wr && i_addr == `VEC_OFF_CMD && i_wdata[0];
  assign exp_fail = bad(PIN_E, pin_ctl) | bad(PROC_E, proc_ctl);
  always_comb begin
    next_pin_ctl  = pin_ctl;
    next_proc_ctl = proc_ctl;
    if (i_wr && i_addr == `VEC_OFF_PIN_CTL) begin
      next_pin_ctl = i_wdata[31:0];
    end
    if (i_wr && i_addr == `VEC_OFF_PROC_CTL) begin
      next_proc_ctl = i_wdata[31:0];
    end
    if (!i_rst_n) begin
      next_pin_ctl  = `VEC_CTL_RST;
      next_proc_ctl = `VEC_CTL_RST;
    end
  end
  always_ff @(posedge i_clk) begin
    pin_ctl  <= next_pin_ctl;
    proc_ctl <= next_proc_ctl;
  end
  // ======================================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    start_w;
  endsequence
  sequence s_read(a);
    i_rd && i_addr == a;
  endsequence
  chk_done_after_start: assert property (s_start |=> o_entry_done)
    else $error("no done after start");
  chk_done_no_start: assert property (!start_w |=> !o_entry_done)
    else $error("done without start");
  chk_fail_verdict: assert property (s_start |=> o_entry_fail == $past(exp_fail))
    else $error("wrong entry verdict");
  chk_fail_with_done: assert property (o_entry_fail |-> o_entry_done)
    else $error("fail without done");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 64'h0000_0000_0000_0000)
    else $error("read data outside read slot");
  chk_pin_cap_read: assert property (s_read(`VEC_OFF_PIN_CAP) |=> o_rdata == PIN_S)
    else $error("pin capability read wrong");
  chk_proc_cap_read: assert property (s_read(`VEC_OFF_PROC_CAP) |=> o_rdata == PROC_S)
    else $error("primary capability read wrong");
  chk_pin_true_read: assert property (s_read(`VEC_OFF_PIN_TRUE_CAP) |=>
    o_rdata == (TRUE_EN ? P_PIN_TRUE_CAP : 64'h0000_0000_0000_0000))
    else $error("pin true capability read wrong");
  chk_proc_true_read: assert property (s_read(`VEC_OFF_PROC_TRUE_CAP) |=>
    o_rdata == (TRUE_EN ? P_PROC_TRUE_CAP : 64'h0000_0000_0000_0000))
    else $error("primary true capability read wrong");
endmodule : vec_entry_check_assertions
`default_nettype wire

// ### bench/vec_entry_check_tb.sv
// Testbench: register reads, entry checks in both capability modes, interrupt
// Assumes design files and the checker are compiled before this file
`timescale 1ns/100ps
`default_nettype none
`include "vec_consts.svh"
module vec_entry_check_tb;
  import vec_pkg::*;
  // ======================================================================
  // Signals and instances
  localparam vec_cap_t PIN_T  = 64'h0000_007f_0000_0002;
  localparam vec_cap_t PROC_T = `VEC_PROC_TRUE_CAP_DEF;
  localparam vec_cap_t PIN_S  = `VEC_PIN_CAP_DEF | {32'h0000_0000, `VEC_PIN_DEF1};
  localparam vec_cap_t PROC_S = `VEC_PROC_CAP_DEF | {32'h0000_0000, `VEC_PROC_DEF1};
  logic        i_clk;
  logic        i_rst_n;
  logic        i_wr;
  logic        i_rd;
  logic [11:0] i_addr;
  logic [63:0] i_wdata;
  logic [63:0] rd_t;
  logic [63:0] rd_s;
  logic        done_t;
  logic        done_s;
  logic        fail_t;
  logic        fail_s;
  logic        irq_t;
  logic        irq_s;
  int          error_cnt = 0;
  int          samples_checked = 0;
  vec_ctl_t    pv[6] = '{32'h0000_0016, 32'h0000_0000, 32'h0000_0002, 32'h0000_0096,
                         32'h0000_0016, 32'h0000_0016};
  vec_ctl_t    qv[6] = '{32'h0401_e172, 32'h0401_e172, 32'h0000_0000, 32'h0401_e172,
                         32'h0401_e173, 32'h0401_e162};
  vec_entry_check #(.P_PIN_TRUE_CAP(PIN_T)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd_t),
    .o_entry_done(done_t), .o_entry_fail(fail_t), .o_irq(irq_t));
  vec_entry_check #(.P_BASIC_CAP(64'h0000_0000_0000_0000)) DUT2 (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rd_s), .o_entry_done(done_s), .o_entry_fail(fail_s), .o_irq(irq_s));
  // ======================================================================
  // Tasks
  function automatic logic bad(input vec_cap_t c, input vec_ctl_t x);
    return (|(c[31:0] & ~x)) | (|(~c[63:32] & x));
  endfunction : bad
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge i_clk);
    i_wr    <= 1'h1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd2(input logic [11:0] a, input logic [63:0] et, input logic [63:0] es);
    @(posedge i_clk);
    i_rd   <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    check(rd_t, et);
    check(rd_s, es);
  endtask : rd2
  task automatic entry(input vec_ctl_t p, input vec_ctl_t q);
    wr(`VEC_OFF_PIN_CTL, {32'h0000_0000, p});
    wr(`VEC_OFF_PROC_CTL, {32'h0000_0000, q});
    wr(`VEC_OFF_CMD, 64'h0000_0000_0000_0001);
    check({62'h0, done_t, fail_t}, {62'h0, 1'h1, bad(PIN_T, p) | bad(PROC_T, q)});
    check({62'h0, done_s, fail_s}, {62'h0, 1'h1, bad(PIN_S, p) | bad(PROC_S, q)});
  endtask : entry
  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // ======================================================================
  // Clock, watchdog, sequence
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    i_rst_n = 1'h0;
    i_wr    = 1'h0;
    i_rd    = 1'h0;
    i_addr  = '0;
    i_wdata = '0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    rd2(`VEC_OFF_PIN_CAP, PIN_S, PIN_S);
    rd2(`VEC_OFF_PROC_CAP, PROC_S, PROC_S);
    rd2(`VEC_OFF_PIN_TRUE_CAP, PIN_T, '0);
    rd2(`VEC_OFF_PROC_TRUE_CAP, PROC_T, '0);
    rd2(12'h123, '0, '0);
    rd2(`VEC_OFF_BASIC_CAP, `VEC_BASIC_CAP_DEF, '0);
    wr(`VEC_OFF_PIN_CAP, '1);
    rd2(`VEC_OFF_PIN_CAP, PIN_S, PIN_S);
    for (int k = 0; k < 6; k++) entry(pv[k], qv[k]);
    rd2(`VEC_OFF_PIN_CTL, 64'h0000_0000_0000_0016, 64'h0000_0000_0000_0016);
    rd2(`VEC_OFF_STATUS, 64'h0000_0000_0000_0003, 64'h0000_0000_0000_0003);
    wr(`VEC_OFF_CLEAR, 64'h0000_0000_0000_0003);
    wr(`VEC_OFF_ENABLE, 64'h0000_0000_0000_0002);
    rd2(`VEC_OFF_STATUS, '0, '0);
    check({62'h0, irq_t, irq_s}, '0);
    entry(32'h0000_0000, 32'h0401_e172);
    rd2(`VEC_OFF_STATUS, 64'h0000_0000_0000_0002, 64'h0000_0000_0000_0002);
    check({62'h0, irq_t, irq_s}, 64'h0000_0000_0000_0003);
    rd2(`VEC_OFF_VIOL_PIN, 64'h0000_0000_0000_0002, 64'h0000_0000_0000_0016);
    rd2(`VEC_OFF_VIOL_PROC, '0, '0);
    rd2(`VEC_OFF_COUNT, 64'h0000_0000_0004_0003, 64'h0000_0000_0006_0001);
    wr(`VEC_OFF_ENABLE, 64'h0000_0000_0000_0001);
    rd2(`VEC_OFF_ENABLE, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001);
    check({62'h0, irq_t, irq_s}, '0);
    stop_test();
  end
endmodule : vec_entry_check_tb
bind vec_entry_check vec_entry_check_assertions #(.P_BASIC_CAP(P_BASIC_CAP),
  .P_PIN_CAP(P_PIN_CAP), .P_PIN_TRUE_CAP(P_PIN_TRUE_CAP), .P_PROC_CAP(P_PROC_CAP),
  .P_PROC_TRUE_CAP(P_PROC_TRUE_CAP)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_entry_done(o_entry_done), .o_entry_fail(o_entry_fail), .o_irq(o_irq));
`default_nettype wire
